// ==== rtl/ldr_config_regs.v ====
// I2C slave register bank: setup registers, sticky fault flags, identity.
// Assumes SCL and SDA arrive as raw pins and fault detectors are on mclk_in.
`include "ldr_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module ldr_config_regs (
    input wire mclk_in, // 10 MHz system clock
    input wire reset_n_in, // synchronous reset, active low
    input wire scl_in, // I2C clock pin level
    input wire sda_in, // I2C data pin level
    output reg sda_out, // I2C data drive value, always 0
    output reg sda_oe_n_out, // low while pulling SDA low
    input wire [5:0] fault_set_in, // detector pulses, bit order as flags
    input wire [5:0] fault_active_in, // detector condition still present
    input wire mode_pin_float_in, // dimming mode pin floats
    input wire spread_pin_float_in, // spread config pin floats
    input wire config_pin_a_float_in, // frequency pin floats
    input wire thr_pin_float_in, // short threshold pin floats
    input wire phase_pin_in, // phase shift requested by pins
    input wire [1:0] mode_pin_in, // dimming mode from pin
    input wire spread_jitter_pin_in, // jitter range from pin
    input wire [1:0] thr_pin_in, // threshold from pin
    output reg hot_current_reduce_en_out, // hot current reduction enable
    output reg [1:0] dim_mode_out, // dimming mode
    output reg mix_transfer_point_out, // 0 25%, 1 12.5%
    output reg mix_output_config_pin_a_sel_out, // 0 200Hz, 1 23kHz
    output reg [1:0] spread_mod_rate_out, // spread modulation rate
    output reg spread_jitter_range_out, // spread jitter range
    output reg phase_shift_en_out, // phase shifting enable
    output reg [1:0] short_threshold_sel_out, // short threshold code
    output reg [1:0] switch_config_pin_a_sel_out, // switching frequency code
    output reg [2:0] active_channel_count_out, // active channel code
    output reg all_short_protect_en_out, // all-strings short protection
    output reg comp_saturation_time_sel_out, // 0 20ms, 1 40ms
    output reg [5:0] latched_off_out, // latched-off state per flag
    output reg fault_output_pin_out // fault output, low on fault
);
    localparam ST_IDLE = 3'h0;
    localparam ST_ADDR = 3'h1;
    localparam ST_INDEX = 3'h2;
    localparam ST_WDATA = 3'h3;
    localparam ST_RDATA = 3'h4;
    localparam ST_ACK = 3'h5;
    localparam ST_RACK = 3'h6;
    localparam ST_SKIP = 3'h7;
    localparam integer RELEASE_CYC_I = `LDR_RELEASE_CYC;
    localparam [15:0] RELEASE_CYC = RELEASE_CYC_I[15:0];

    wire scl_s;
    wire sda_s;
    wire mode_float_s, spread_float_s, config_pin_a_float_s, thr_float_s;
    wire phase_pin_s, jitter_pin_s;
    wire [1:0] mode_pin_s;
    wire [1:0] thr_pin_s;
    reg scl_d_r;
    reg sda_d_r;
    reg [2:0] state_r;
    reg [2:0] after_ack_r;
    reg [2:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] index_r;
    reg [7:0] setup_one_r;
    reg [7:0] setup_two_r;
    reg [1:0] fault_ctrl_r;
    reg [5:0] flags_r;
    reg [15:0] release_cnt_r;
    reg [7:0] rd_byte;
    reg [5:0] rd_clear;

    // ==================================================
    // Pin synchronisers
    ldr_sync2 #(.RST_VAL(1'b1)) u_sync_scl (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(scl_in),
        .sync_out(scl_s)
    );
    ldr_sync2 #(.RST_VAL(1'b1)) u_sync_sda (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(sda_in),
        .sync_out(sda_s)
    );
    // Configuration pins are slow levels, but they still pass two flops against metastability.
    ldr_sync2 #(.RST_VAL(1'b1)) u_sync_mfl (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(mode_pin_float_in),
        .sync_out(mode_float_s)
    );
    ldr_sync2 #(.RST_VAL(1'b1)) u_sync_sfl (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(spread_pin_float_in),
        .sync_out(spread_float_s)
    );
    ldr_sync2 #(.RST_VAL(1'b1)) u_sync_afl (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(config_pin_a_float_in),
        .sync_out(config_pin_a_float_s)
    );
    ldr_sync2 #(.RST_VAL(1'b1)) u_sync_tfl (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(thr_pin_float_in),
        .sync_out(thr_float_s)
    );
    ldr_sync2 #(.RST_VAL(1'b0)) u_sync_ph (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(phase_pin_in),
        .sync_out(phase_pin_s)
    );
    ldr_sync2 #(.RST_VAL(1'b0)) u_sync_sj (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(spread_jitter_pin_in),
        .sync_out(jitter_pin_s)
    );
    ldr_sync2 #(.RST_VAL(1'b0)) u_sync_m0 (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(mode_pin_in[0]),
        .sync_out(mode_pin_s[0])
    );
    ldr_sync2 #(.RST_VAL(1'b0)) u_sync_m1 (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(mode_pin_in[1]),
        .sync_out(mode_pin_s[1])
    );
    ldr_sync2 #(.RST_VAL(1'b0)) u_sync_t0 (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(thr_pin_in[0]),
        .sync_out(thr_pin_s[0])
    );
    ldr_sync2 #(.RST_VAL(1'b0)) u_sync_t1 (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .async_in(thr_pin_in[1]),
        .sync_out(thr_pin_s[1])
    );

    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_cond = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ==================================================
    // Read data selection
    always @* begin
        rd_byte = 8'h00;
        case (index_r)
            `LDR_REG_SETUP_ONE: rd_byte = setup_one_r;
            `LDR_REG_SETUP_TWO: rd_byte = setup_two_r;
            `LDR_REG_FAULT: rd_byte = {fault_ctrl_r, flags_r};
            `LDR_REG_IDENTITY: rd_byte = `LDR_IDENTITY_VAL;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==================================================
    // Bus protocol and register writes
    always @(posedge mclk_in) begin
        rd_clear <= 6'h00;
        if (!reset_n_in) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            state_r <= ST_IDLE;
            after_ack_r <= ST_IDLE;
            bit_cnt_r <= 3'h0;
            shift_r <= 8'h00;
            index_r <= 8'h00;
            sda_out <= 1'b0;
            sda_oe_n_out <= 1'b1;
            setup_one_r <= `LDR_SETUP_ONE_RST;
            setup_two_r <= `LDR_SETUP_TWO_RST;
            fault_ctrl_r <= `LDR_FAULT_CTRL_RST;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            if (start_cond) begin
                state_r <= ST_IDLE;
                bit_cnt_r <= 3'h0;
                sda_oe_n_out <= 1'b1;
            end else if (stop_cond) begin
                state_r <= ST_IDLE;
                sda_oe_n_out <= 1'b1;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        // A start waits here for its own SCL fall, which must not end a byte.
                        if (scl_fall) begin
                            bit_cnt_r <= 3'h0;
                            state_r <= ST_ADDR;
                        end
                    end
                    ST_ADDR, ST_INDEX, ST_WDATA: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s};
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                        end
                        if (scl_fall && bit_cnt_r == 3'h0) begin
                            // Eighth bit sampled; decide on acknowledge.
                            if (state_r == ST_ADDR) begin
                                if (shift_r[7:1] == `LDR_SLAVE_ADDR) begin
                                    sda_oe_n_out <= 1'b0;
                                    state_r <= ST_ACK;
                                    after_ack_r <= shift_r[0] ? ST_RDATA : ST_INDEX;
                                end else begin
                                    state_r <= ST_SKIP;
                                end
                            end else if (state_r == ST_INDEX) begin
                                index_r <= shift_r;
                                sda_oe_n_out <= 1'b0;
                                state_r <= ST_ACK;
                                after_ack_r <= ST_WDATA;
                            end else begin
                                // Read-only bits and the identity ignore writes.
                                case (index_r)
                                    `LDR_REG_SETUP_ONE: setup_one_r <= shift_r;
                                    `LDR_REG_SETUP_TWO: setup_two_r <= shift_r;
                                    `LDR_REG_FAULT: fault_ctrl_r <= shift_r[7:6];
                                    default: fault_ctrl_r <= fault_ctrl_r;
                                endcase
                                sda_oe_n_out <= 1'b0;
                                state_r <= ST_ACK;
                                after_ack_r <= ST_WDATA;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= 3'h0;
                            state_r <= after_ack_r;
                            if (after_ack_r == ST_RDATA) begin
                                shift_r <= rd_byte;
                                sda_oe_n_out <= rd_byte[7];
                                if (index_r == `LDR_REG_FAULT) begin
                                    rd_clear <= flags_r;
                                end
                            end else begin
                                sda_oe_n_out <= 1'b1;
                            end
                        end
                    end
                    ST_RDATA: begin
                        if (scl_fall) begin
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                            if (bit_cnt_r == 3'h7) begin
                                sda_oe_n_out <= 1'b1;
                                state_r <= ST_RACK;
                            end else begin
                                shift_r <= {shift_r[6:0], 1'b0};
                                sda_oe_n_out <= shift_r[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        // Master nack ends the read; ack repeats the same index.
                        if (scl_rise) begin
                            state_r <= sda_s ? ST_SKIP : ST_ACK;
                            after_ack_r <= ST_RDATA;
                        end
                    end
                    ST_SKIP: state_r <= ST_SKIP;
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end

    // ==================================================
    // Sticky fault flags and fault output
    always @(posedge mclk_in) begin
        if (!reset_n_in) begin
            flags_r <= 6'h00;
            latched_off_out <= 6'h00;
            release_cnt_r <= 16'h0000;
            fault_output_pin_out <= 1'b1;
        end else begin
            // A new event in the clearing cycle keeps its flag set.
            flags_r <= (flags_r & ~rd_clear) | fault_set_in;
            latched_off_out <= (latched_off_out & ~rd_clear) | fault_set_in;
            if ((|fault_set_in) || (|fault_active_in) || (|latched_off_out)) begin
                fault_output_pin_out <= 1'b0;
                release_cnt_r <= RELEASE_CYC;
            end else if (release_cnt_r > 16'h0001) begin
                release_cnt_r <= release_cnt_r - 16'h0001;
            end else begin
                release_cnt_r <= 16'h0000;
                fault_output_pin_out <= 1'b1;
            end
        end
    end

    // ==================================================
    // Effective settings: a connected pin wins over the register; the phase pin is ORed with its register bit
    always @(posedge mclk_in) begin
        if (!reset_n_in) begin
            hot_current_reduce_en_out <= 1'b1;
            dim_mode_out <= 2'h0;
            mix_transfer_point_out <= 1'b0;
            mix_output_config_pin_a_sel_out <= 1'b0;
            spread_mod_rate_out <= 2'h3;
            spread_jitter_range_out <= 1'b0;
            phase_shift_en_out <= 1'b0;
            short_threshold_sel_out <= 2'h1;
            switch_config_pin_a_sel_out <= 2'h1;
            active_channel_count_out <= 3'h0;
            all_short_protect_en_out <= 1'b0;
            comp_saturation_time_sel_out <= 1'b0;
        end else begin
            hot_current_reduce_en_out <= setup_one_r[`LDR_HOT_BIT];
            dim_mode_out <= mode_float_s ?
                setup_one_r[`LDR_MODE_HI:`LDR_MODE_LO] : mode_pin_s;
            mix_transfer_point_out <= setup_one_r[`LDR_MIX_TRANSFER_POINT_BIT];
            mix_output_config_pin_a_sel_out <= setup_one_r[`LDR_MIX_OUTPUT_CONFIG_PIN_A_SEL_BIT];
            spread_mod_rate_out <= spread_float_s ?
                setup_one_r[`LDR_SMR_HI:`LDR_SMR_LO] : 2'h1;
            spread_jitter_range_out <= spread_float_s ?
                setup_one_r[`LDR_SJR_BIT] : jitter_pin_s;
            phase_shift_en_out <= setup_two_r[`LDR_PHASE_BIT] | phase_pin_s;
            short_threshold_sel_out <= thr_float_s ?
                setup_two_r[`LDR_THR_HI:`LDR_THR_LO] : thr_pin_s;
            // A driven frequency pin leaves the code at its reset value.
            switch_config_pin_a_sel_out <= config_pin_a_float_s ?
                setup_two_r[`LDR_FSW_HI:`LDR_FSW_LO] : 2'h1;
            active_channel_count_out <= setup_two_r[`LDR_CH_HI:`LDR_CH_LO];
            all_short_protect_en_out <= fault_ctrl_r[1];
            comp_saturation_time_sel_out <= fault_ctrl_r[0];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ldr_consts.vh ====
// Constants for the LED driver configuration register bank.
// Assumes a 10 MHz system clock; included by the register bank and the bench.
`ifndef LDR_CONSTS_VH
`define LDR_CONSTS_VH
// ==================================================
// Bus address and register indices
`define LDR_SLAVE_ADDR 7'h38
`define LDR_REG_SETUP_ONE 8'h00
`define LDR_REG_SETUP_TWO 8'h01
`define LDR_REG_FAULT 8'h02
`define LDR_REG_IDENTITY 8'h03
// ==================================================
// Reset values
`define LDR_SETUP_ONE_RST 8'h86
`define LDR_SETUP_TWO_RST 8'h28
`define LDR_FAULT_CTRL_RST 2'h0
// Arbitrary neutral identity value.
`define LDR_IDENTITY_VAL 8'h5a
// ==================================================
// Field positions
`define LDR_HOT_BIT 7
`define LDR_MODE_HI 6
`define LDR_MODE_LO 5
`define LDR_MIX_TRANSFER_POINT_BIT 4
`define LDR_MIX_OUTPUT_CONFIG_PIN_A_SEL_BIT 3
`define LDR_SMR_HI 2
`define LDR_SMR_LO 1
`define LDR_SJR_BIT 0
`define LDR_PHASE_BIT 7
`define LDR_THR_HI 6
`define LDR_THR_LO 5
`define LDR_FSW_HI 4
`define LDR_FSW_LO 3
`define LDR_CH_HI 2
`define LDR_CH_LO 0
`define LDR_SEN_BIT 7
`define LDR_COMP_SATURATION_TIME_SEL_BIT 6
`define LDR_FLAG_HI 5
// ==================================================
// Timing: fault output release delay
`define LDR_CLK_KHZ 10000
`define LDR_RELEASE_US 750
`define LDR_RELEASE_CYC ((`LDR_RELEASE_US * `LDR_CLK_KHZ) / 1000)
`endif

// ==== rtl/ldr_sync2.v ====
// Two-flop synchroniser for one pin level.
// Assumes the input is asynchronous to mclk_in.
`timescale 1ns/100ps
`default_nettype none
module ldr_sync2 #(
    parameter RST_VAL = 1'b1
) (
    input wire mclk_in, // system clock
    input wire reset_n_in, // synchronous reset, active low
    input wire async_in, // raw pin level
    output reg sync_out // synchronised level
);
    reg meta_r;
    always @(posedge mclk_in) begin
        if (!reset_n_in) begin
            meta_r <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ==== dv/ldr_i2c_host.sv ====
// Behavioural I2C host that reaches the register bank over SCL and SDA.
// Assumes the bench resolves the open-drain SDA line and feeds it back.
`timescale 1ns/100ps
`default_nettype none
module ldr_i2c_host (
    input wire logic clk_in, // system clock, paces the bus
    input wire logic sda_line_in, // resolved SDA level
    output logic scl_out, // SCL, stands high between frames
    output logic sda_out // SDA, 1 releases, 0 pulls low
);
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // A quarter bit is two system cycles, so one bit lasts 800 ns.
    task automatic q();
        repeat (2) @(negedge clk_in);
    endtask
    task automatic bit_io(input logic b, output logic s);
        sda_out = b;
        q();
        scl_out = 1'b1;
        q();
        s = sda_line_in;
        q();
        scl_out = 1'b0;
        q();
    endtask
    // Also serves as repeated start, since SDA is raised while SCL is low.
    task automatic start();
        sda_out = 1'b1;
        q();
        scl_out = 1'b1;
        q();
        sda_out = 1'b0;
        q();
        scl_out = 1'b0;
        q();
    endtask
    // The ninth bit is always released: it reads the ack, or ends a read with a nack.
    task automatic byte_io(input logic [7:0] d, output logic [7:0] r, output logic ack_n);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(1'b1, ack_n);
    endtask
    task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] idx,
                        input logic [7:0] wd, output logic [7:0] rdat, output logic ack_n);
        logic [7:0] r;
        logic k;
        start();
        byte_io({a, 1'b0}, r, ack_n);
        byte_io(idx, r, k);
        if (rd) begin
            start();
            byte_io({a, 1'b1}, r, k);
            wd = 8'hff;
        end
        byte_io(wd, rdat, k);
        sda_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_out = 1'b1;
        q();
    endtask
endmodule
`default_nettype wire

// ==== dv/ldr_config_regs_monitor.sv ====
// Concurrent checks on the register bank's ports.
// Assumes a bind onto ldr_config_regs and the 7500-cycle release delay.
`timescale 1ns/100ps
`default_nettype none
module ldr_config_regs_monitor (
    input wire logic mclk_in, // system clock
    input wire logic reset_n_in, // synchronous reset, active low
    input wire logic scl_in, // bus clock pin
    input wire logic sda_oe_n_out, // SDA pull enable
    input wire logic [5:0] fault_set_in, // detector set pulses
    input wire logic [5:0] fault_active_in, // detector conditions
    input wire logic mode_pin_float_in, // mode pin floats
    input wire logic [1:0] mode_pin_in, // mode pin value
    input wire logic config_pin_a_float_in, // frequency pin floats
    input wire logic phase_pin_in, // phase pin request
    input wire logic hot_current_reduce_en_out, // hot reduction enable
    input wire logic [1:0] dim_mode_out, // dimming mode
    input wire logic [1:0] switch_config_pin_a_sel_out, // switching frequency code
    input wire logic phase_shift_en_out, // phase shifting enable
    input wire logic [5:0] latched_off_out, // latched-off states
    input wire logic fault_output_pin_out // fault output
);
    localparam int REL = 7500;
    localparam int REL_LO = 7497;
    localparam int REL_HI = 7503;
    logic [13:0] clr_cnt_r;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ==================================================
    // Cycles since every fault cause went away
    always @(posedge mclk_in) begin
        if (!reset_n_in || (fault_set_in | fault_active_in | latched_off_out) != 6'h00)
            clr_cnt_r <= 14'h0000;
        else if (clr_cnt_r != 14'h3fff)
            clr_cnt_r <= clr_cnt_r + 14'h0001;
    end
    // ==================================================
    // Properties
    chk_reset_state: assert property (disable iff (1'b0) !reset_n_in |=> sda_oe_n_out
        && fault_output_pin_out && hot_current_reduce_en_out) else $error("reset state wrong");
    chk_fault_low: assert property ((fault_set_in != 6'h00) |-> ##[1:2]
        !fault_output_pin_out) else $error("fault output not pulled low");
    chk_flag_latch: assert property ($rose(|fault_set_in) |-> ##[1:2]
        (latched_off_out != 6'h00)) else $error("fault flag not latched");
    chk_flag_sticky: assert property (scl_in [*6] |->
        (($past(latched_off_out) & ~latched_off_out) == 6'h00)) else $error("flag lost");
    chk_release_delay: assert property ($rose(fault_output_pin_out) |->
        clr_cnt_r >= REL_LO && clr_cnt_r <= REL_HI) else $error("release delay wrong");
    chk_release_late: assert property ((clr_cnt_r == REL + 4) |->
        fault_output_pin_out) else $error("fault output never released");
    chk_active_holds: assert property ((fault_active_in != 6'h00) [*2] |->
        !fault_output_pin_out) else $error("fault output high while active");
    chk_ack_stable: assert property (scl_in [*5] |-> $stable(sda_oe_n_out))
        else $error("SDA drive changed while SCL high");
    chk_mode_pin: assert property ((!mode_pin_float_in && $stable(mode_pin_in)) [*4]
        |-> dim_mode_out == mode_pin_in) else $error("mode pin not obeyed");
    chk_config_pin_a_pin: assert property ((!config_pin_a_float_in) [*4]
        |-> switch_config_pin_a_sel_out == 2'b01) else $error("frequency pin not obeyed");
    chk_phase_pin: assert property (phase_pin_in [*4] |-> phase_shift_en_out)
        else $error("phase pin not obeyed");
endmodule
bind ldr_config_regs ldr_config_regs_monitor mon (.*);
`default_nettype wire

// ==== dv/tb_ldr_config_regs.sv ====
// Self-checking bench for the LED driver configuration register bank.
// Assumes ldr_consts.vh on the include path and a pulled-up SDA line.
`include "ldr_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_ldr_config_regs;
    logic mclk = 1'b0, reset_n = 1'b0, scl, host_sda, sda_o, sda_oe_n;
    logic [5:0] f_set = 6'h00, f_act = 6'h00, latched;
    logic m_fl = 1'b1, s_fl = 1'b1, a_fl = 1'b1, t_fl = 1'b1, ph_pin = 1'b0, sj_pin = 1'b0;
    logic [1:0] m_pin = 2'b00, t_pin = 2'b00, dim, smr, thr, fsw;
    logic hot, tp, fr, sjr, ph, all_short_protect_en, tc, fpin, ackn;
    logic [2:0] ch;
    logic [7:0] rdat, o [3];
    int mismatches = 0, check_count = 0;
    wire logic sda_line = host_sda & (sda_oe_n | sda_o);
    // Columns: write flag, index, data written, value expected back.
    logic [24:0] rows [19] = '{
        {1'b0, 8'h00, 8'h00, 8'h86}, {1'b0, 8'h01, 8'h00, 8'h28},
        {1'b0, 8'h02, 8'h00, 8'h00}, {1'b0, 8'h03, 8'h00, `LDR_IDENTITY_VAL},
        {1'b1, 8'h00, 8'h00, 8'h00}, {1'b1, 8'h00, 8'h2a, 8'h2a},
        {1'b1, 8'h00, 8'h55, 8'h55}, {1'b1, 8'h00, 8'hff, 8'hff},
        {1'b1, 8'h01, 8'h29, 8'h29}, {1'b1, 8'h01, 8'h0a, 8'h0a},
        {1'b1, 8'h01, 8'h13, 8'h13}, {1'b1, 8'h01, 8'h14, 8'h14},
        {1'b1, 8'h01, 8'h55, 8'h55}, {1'b1, 8'h01, 8'h16, 8'h16},
        {1'b1, 8'h01, 8'hff, 8'hff}, {1'b1, 8'h02, 8'hff, 8'hc0},
        {1'b1, 8'h02, 8'h40, 8'h40}, {1'b1, 8'h03, 8'h00, `LDR_IDENTITY_VAL},
        {1'b1, 8'h04, 8'h55, 8'h00}};
    assign o[0] = {hot, dim, tp, fr, smr, sjr};
    assign o[1] = {ph, thr, fsw, ch};
    assign o[2] = {all_short_protect_en, tc, 6'h00};
    initial begin
        forever #50 mclk = ~mclk;
    end
    ldr_i2c_host host (.clk_in(mclk), .sda_line_in(sda_line), .scl_out(scl), .sda_out(host_sda));
    ldr_config_regs uut (.mclk_in(mclk), .reset_n_in(reset_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .fault_set_in(f_set), .fault_active_in(f_act),
        .mode_pin_float_in(m_fl), .spread_pin_float_in(s_fl), .config_pin_a_float_in(a_fl),
        .thr_pin_float_in(t_fl), .phase_pin_in(ph_pin), .mode_pin_in(m_pin),
        .spread_jitter_pin_in(sj_pin), .thr_pin_in(t_pin), .hot_current_reduce_en_out(hot),
        .dim_mode_out(dim), .mix_transfer_point_out(tp), .mix_output_config_pin_a_sel_out(fr),
        .spread_mod_rate_out(smr), .spread_jitter_range_out(sjr), .phase_shift_en_out(ph),
        .short_threshold_sel_out(thr), .switch_config_pin_a_sel_out(fsw),
        .active_channel_count_out(ch), .all_short_protect_en_out(all_short_protect_en),
        .comp_saturation_time_sel_out(tc), .latched_off_out(latched),
        .fault_output_pin_out(fpin));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // The whole run needs about 18300 cycles.
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        foreach (rows[i]) begin
            if (rows[i][24]) begin
                host.xfer(7'h38, 1'b0, rows[i][23:16], rows[i][15:8], rdat, ackn);
                chk("write_ack", {7'h00, ackn}, 8'h00);
            end
            host.xfer(7'h38, 1'b1, rows[i][23:16], 8'h00, rdat, ackn);
            chk("readback", rdat, rows[i][7:0]);
            if (rows[i][23:16] < 8'h03)
                chk("config_out", o[rows[i][17:16]], rows[i][7:0]);
        end
        // A foreign address is left unanswered and changes nothing.
        host.xfer(7'h39, 1'b0, 8'h00, 8'h12, rdat, ackn);
        chk("foreign_ack", {7'h00, ackn}, 8'h01);
        host.xfer(7'h38, 1'b1, 8'h00, 8'h00, rdat, ackn);
        chk("foreign_effect", rdat, 8'hff);
        f_set = 6'h08;
        f_act = 6'h02;
        repeat (5) @(negedge mclk);
        f_set = 6'h00;
        f_act = 6'h00;
        chk("fault_pin", {7'h00, fpin}, 8'h00);
        chk("latched", {2'h0, latched}, 8'h08);
        host.xfer(7'h38, 1'b1, 8'h02, 8'h00, rdat, ackn);
        chk("flag_read", rdat, 8'h48);
        chk("latch_release", {2'h0, latched}, 8'h00);
        host.xfer(7'h38, 1'b1, 8'h02, 8'h00, rdat, ackn);
        chk("flag_cleared", rdat, 8'h40);
        repeat (7000) @(negedge mclk);
        chk("fault_hold", {7'h00, fpin}, 8'h00);
        repeat (400) @(negedge mclk);
        chk("fault_release", {7'h00, fpin}, 8'h01);
        {m_fl, s_fl, a_fl, t_fl, ph_pin, sj_pin, m_pin} = 8'h0e;
        repeat (8) @(negedge mclk);
        chk("pin_override", {ph, dim, smr, sjr, fsw}, 8'hcd);
        chk("thr_override", {6'h00, thr}, 8'h00);
        {m_fl, s_fl, a_fl, t_fl, ph_pin, sj_pin, m_pin} = 8'hf0;
        reset_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk("reset_out0", o[0], 8'h86);
        chk("reset_out1", o[1], 8'h28);
        chk("reset_pins", {6'h00, sda_oe_n, fpin}, 8'h03);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        host.xfer(7'h38, 1'b1, 8'h01, 8'h00, rdat, ackn);
        chk("reset_read", rdat, 8'h28);
        report_and_stop();
    end
endmodule
`default_nettype wire
